// File: adc_seq_pkg.sv
// Constants, field layouts and carrier types for the converter sequencer
package adc_seq_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL2  = 8'h00;
    localparam logic [7:0] OFS_CTRL3  = 8'h04;
    localparam logic [7:0] OFS_CTRL4  = 8'h08;
    localparam logic [7:0] OFS_CTRL5  = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h20;
    localparam int         RES_STRIDE = 4;

    // Control and status field positions
    localparam int C2_POWER_UP   = 7;
    localparam int C2_WAIT_PD    = 2;
    localparam int C2_IRQ_EN     = 1;
    localparam int C3_SINGLE     = 3;
    localparam int C4_RES10      = 7;
    localparam int C4_SMP_LO     = 5;
    localparam int C4_PRE_LO     = 0;
    localparam int C5_LEFT       = 7;
    localparam int C5_EIGHT      = 6;
    localparam int C5_CONT       = 5;
    localparam int C5_MULTI      = 4;
    localparam int C5_SPECIAL    = 3;
    localparam int C5_CH_LO      = 0;
    localparam int ST_SEQ_FLAG   = 15;
    localparam int ST_IDX_LO     = 16;
    localparam int ST_BUSY       = 19;

    // Timing in module clocks and result widths in bits
    localparam logic [4:0] CAP_CLKS     = 5'd2;
    localparam logic [4:0] AMP_CLKS     = 5'd4;
    localparam logic [4:0] DIRECT_BASE  = 5'd2;
    localparam logic [4:0] CONV8_CLKS   = 5'd10;
    localparam logic [4:0] CONV10_CLKS  = 5'd12;
    localparam logic [3:0] BITS8        = 4'd8;
    localparam logic [3:0] BITS10       = 4'd10;

    // Special channel codes and reference selects
    localparam logic [2:0] SPC_LOW  = 3'h4;
    localparam logic [2:0] SPC_HIGH = 3'h5;
    localparam logic [2:0] SPC_MID  = 3'h6;

    // Reset values
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [15:0] RES_RESET  = 16'h0000;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

    // Reference point selection for the analog side
    typedef enum logic [1:0] {
        REF_NONE,
        REF_LOW,
        REF_HIGH,
        REF_MID
    } ref_sel_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CAP,
        ST_AMP,
        ST_DIRECT,
        ST_CONV
    } seq_state_t;

    // Controls toward multiplexer, sample/hold and DAC arrays
    typedef struct packed {
        logic       powered;
        logic [2:0] channel;
        ref_sel_t   ref_sel;
        logic       sample_cap;
        logic       sample_amp;
        logic       sample_direct;
        logic       converting;
        logic       res10;
        logic [9:0] dac_code;
    } analog_ctl_t;

endpackage : adc_seq_pkg

// File: adc_sequencer_control.sv
// Sequencer, timing and register file of the 8-channel SAR converter
//
// Function
// R1: Eight channels, 8 or 10 bit resolution
// R2: Sequences of one, four or eight conversions
// R3: Multi select scans channels, else repeats one
// R4: Continuous select restarts sequence after completion
// R5: Special select converts low, high, mid reference
// R6: Channel bits give channel or first channel
// R7: Length from eight select and single select
// R8: Direct sample phase lasts 2,4,8,16 clocks
// R9: Fourth or fifth control write restarts sequence
// R10: Continuous runs until stopped, powered down, reset
// R11: STOP, or WAIT with enable, stops conversion
// R12: Sequence flag set at each sequence end
// R13: Result flag set when its result loads; a conversion end in a restart cycle sets the flag but loads no result
// R14: Sequence completion can raise an interrupt
// R15: Sample phases of 2 then 4 clocks
// R16: Conversion takes 10 or 12 module clocks
// R17: Binary search against generated reference potentials
// R18: Approximation copied justified into result register
// R19: Five bit modulus prescaler divides 1..32
// R20: Prescaler output divided by two
// R21: Wait ignored while wait enable clear
// R22: Power down aborts the running sequence
// R23: Control write clears flags, cancels interrupt
// R24: Results fill consecutive registers from first
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps

module adc_sequencer_control
    import adc_seq_pkg::*;
#(
    parameter int NUM_CH = 8
) (
    input  wire logic         i_ref_clk,   // Peripheral clock, 200 MHz
    input  wire logic         i_rst_n,     // Async reset, active low
    input  wire logic         psel,        // APB select
    input  wire logic         penable,     // APB access phase
    input  wire logic         pwrite,      // APB direction
    input  wire logic [7:0]   paddr,       // APB byte address
    input  wire logic [31:0]  pwdata,      // APB write data
    output logic [31:0]       prdata,      // APB read data
    output logic              pready,      // APB ready
    output logic              pslverr,     // APB error, unmapped
    input  wire logic         i_stop,      // Processor in STOP
    input  wire logic         i_wait,      // Processor in WAIT
    input  wire logic         i_compare,   // Sample at or above DAC
    output analog_ctl_t       o_analog,    // Analog side controls
    output logic              o_irq        // Sequence complete request
);

    // Control registers
    logic [7:0]        ctrl2;
    logic [7:0]        ctrl3;
    logic [7:0]        ctrl4;
    logic [7:0]        ctrl5;
    logic              seq_flag;           // Sequence complete
    logic [NUM_CH-1:0] conv_flag;          // Per result complete
    logic [15:0]       result [NUM_CH];    // Result registers

    // Sequencer state
    seq_state_t        state;
    logic [4:0]        phase_cnt;          // Module clocks in phase
    logic [2:0]        conv_idx;           // Conversion in sequence
    logic [9:0]        sar;                // Approximation register
    logic [4:0]        pre_cnt;            // Prescaler modulus count
    logic              half;               // Divide by two stage

    // Bus decode
    wire        setup     = psel & ~penable;
    wire        wr        = psel & penable & pwrite;
    wire        hit_c2    = paddr == OFS_CTRL2;
    wire        hit_c3    = paddr == OFS_CTRL3;
    wire        hit_c4    = paddr == OFS_CTRL4;
    wire        hit_c5    = paddr == OFS_CTRL5;
    wire        hit_st    = paddr == OFS_STATUS;

    // Result window, word aligned
    wire [7:0]  res_off   = paddr - OFS_RESULT;
    wire        hit_res   = (paddr >= OFS_RESULT)
                            && (res_off < 8'(NUM_CH * RES_STRIDE))
                            && (res_off[1:0] == 2'b00);
    wire [2:0]  res_sel   = res_off[4:2];
    wire        mapped    = hit_c2 | hit_c3 | hit_c4 | hit_c5
                            | hit_st | hit_res;

    // Restart and flag clear on fourth or fifth control write
    wire        restart   = wr & (hit_c4 | hit_c5);   // [R9] [R23]
    wire        scf_wclr  = wr & hit_st & pwdata[ST_SEQ_FLAG];

    // Control fields
    wire        power_up  = ctrl2[C2_POWER_UP];
    wire        wait_pd   = ctrl2[C2_WAIT_PD];
    wire        irq_en    = ctrl2[C2_IRQ_EN];

    // Resolution, timing, prescale
    wire        single    = ctrl3[C3_SINGLE];
    wire        res10     = ctrl4[C4_RES10];          // [R1]
    wire [1:0]  smp_sel   = ctrl4[C4_SMP_LO +: 2];
    wire [4:0]  pre_sel   = ctrl4[C4_PRE_LO +: 5];

    // Sequence shape and source
    wire        left_just = ctrl5[C5_LEFT];
    wire        eight     = ctrl5[C5_EIGHT];
    wire        cont      = ctrl5[C5_CONT];
    wire        multi     = ctrl5[C5_MULTI];
    wire        special   = ctrl5[C5_SPECIAL];
    wire [2:0]  ch_base   = ctrl5[C5_CH_LO +: 3];

    // Power state: wait only counts when enabled
    wire        active    = power_up & ~i_stop
                            & ~(i_wait & wait_pd);    // [R11] [R21] [R22]

    // Prescaler: modulus count, then divide by two
    wire        pre_tick  = active & (pre_cnt == pre_sel);        // [R19]
    wire        mod_tick  = pre_tick & half;                      // [R20]
    wire [4:0]  next_pre  = pre_tick ? 5'd0 : pre_cnt + 5'd1;

    // Sequence length: one, four or eight
    wire [2:0]  last_idx  = single ? 3'd0
                            : (eight ? 3'd7 : 3'd3);  // [R2] [R7]
    wire        seq_last  = conv_idx == last_idx;

    // Channel of current conversion
    wire [2:0]  cur_ch    = multi ? ch_base + conv_idx
                            : ch_base;                // [R3] [R6]
    wire        ext_ch    = ~special;

    // Phase lengths in module clocks
    wire [4:0]  direct_len = DIRECT_BASE << smp_sel;              // [R8]
    wire [4:0]  conv_len   = res10 ? CONV10_CLKS : CONV8_CLKS;    // [R16]
    wire [3:0]  res_bits   = res10 ? BITS10 : BITS8;

    // Last tick of each phase
    wire        cap_done   = phase_cnt == CAP_CLKS - 5'd1;        // [R15]
    wire        amp_done   = phase_cnt == AMP_CLKS - 5'd1;        // [R15]
    wire        dir_done   = phase_cnt == direct_len - 5'd1;
    wire        conv_done  = phase_cnt == conv_len - 5'd1;

    // Binary search: trial bit walks from msb down
    wire [3:0]  cur_bit   = res_bits - 4'd1 - phase_cnt[3:0];
    wire        trial     = phase_cnt < {1'b0, res_bits};
    wire [9:0]  bit_mask  = 10'h001 << cur_bit;
    wire [9:0]  msb_mask  = 10'h001 << (res_bits - 4'd1);
    wire [9:0]  next_sar  = (i_compare ? sar : (sar & ~bit_mask))
                            | (bit_mask >> 1);        // [R17]

    // Justified result word
    wire [15:0] res_right = {6'h00, sar};
    wire [15:0] res_left  = res10 ? {sar, 6'h00}
                            : {sar[7:0], 8'h00};
    wire [15:0] res_word  = left_just ? res_left : res_right;     // [R18]

    // Load strobe at end of each conversion
    wire        conv_end  = (state == ST_CONV) & mod_tick & conv_done;
    wire        seq_end   = conv_end & seq_last;

    // Status word for reads
    wire [31:0] status_w  = {12'h000, state != ST_IDLE, conv_idx,
                             seq_flag, 7'h00, conv_flag};

    // Read data selection
    wire [31:0] rd_data   = hit_c2  ? {24'h00_0000, ctrl2}
                          : hit_c3  ? {24'h00_0000, ctrl3}
                          : hit_c4  ? {24'h00_0000, ctrl4}
                          : hit_c5  ? {24'h00_0000, ctrl5}
                          : hit_st  ? status_w
                          : hit_res ? {16'h0000, result[res_sel]}
                          : ZERO_WORD;

    // Zero wait state slave
    assign pready = 1'b1;

    // Read data and error captured in setup phase
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata  <= ZERO_WORD;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? ZERO_WORD : rd_data;
            pslverr <= ~mapped;
        end
    end

    // Control register writes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl2 <= CTRL_RESET;
            ctrl3 <= CTRL_RESET;
            ctrl4 <= CTRL_RESET;
            ctrl5 <= CTRL_RESET;
        end else if (wr) begin
            if (hit_c2) begin
                ctrl2 <= pwdata[7:0];
            end

            if (hit_c3) begin
                ctrl3 <= pwdata[7:0];
            end

            if (hit_c4) begin
                ctrl4 <= pwdata[7:0];
            end

            if (hit_c5) begin
                ctrl5 <= pwdata[7:0];
            end
        end
    end

    // Prescaler and divide by two, cleared while inactive or on restart
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_cnt <= 5'd0;
            half    <= 1'b0;
        end else if (!active || restart) begin
            pre_cnt <= 5'd0;
            half    <= 1'b0;
        end else begin
            pre_cnt <= next_pre; // [R19]
            if (pre_tick) begin
                half <= ~half; // [R20]
            end
        end
    end

    // Sequence state machine
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= ST_IDLE;
            phase_cnt <= 5'd0;
            conv_idx  <= 3'd0;
        end else if (!active) begin
            state     <= ST_IDLE; // [R22] [R10]
            phase_cnt <= 5'd0;
        end else if (restart) begin
            state     <= ST_CAP; // [R9]
            phase_cnt <= 5'd0;
            conv_idx  <= 3'd0; // [R24]
        end else if (mod_tick) begin
            phase_cnt <= phase_cnt + 5'd1;
            unique case (state)
                ST_IDLE: begin
                    phase_cnt <= 5'd0;
                end

                ST_CAP: begin
                    if (cap_done) begin
                        state     <= ST_AMP; // [R15]
                        phase_cnt <= 5'd0;
                    end
                end

                ST_AMP: begin
                    if (amp_done) begin
                        state     <= ST_DIRECT; // [R15]
                        phase_cnt <= 5'd0;
                    end
                end

                ST_DIRECT: begin
                    if (dir_done) begin
                        state     <= ST_CONV; // [R8]
                        phase_cnt <= 5'd0;
                    end
                end

                ST_CONV: begin
                    if (conv_done) begin
                        phase_cnt <= 5'd0;
                        if (!seq_last) begin
                            state    <= ST_CAP;
                            conv_idx <= conv_idx + 3'd1; // [R24]
                        end else if (cont) begin
                            state    <= ST_CAP; // [R4] [R10]
                            conv_idx <= 3'd0;
                        end else begin
                            state    <= ST_IDLE; // [R4]
                        end
                    end
                end
            endcase
        end
    end

    // Successive approximation register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sar <= 10'h000;
        end else if (state == ST_DIRECT && mod_tick && dir_done) begin
            sar <= msb_mask; // [R17]
        end else if (state == ST_CONV && mod_tick && trial) begin
            sar <= next_sar; // [R17]
        end
    end

    // Result registers load at conversion end
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result[i] <= RES_RESET;
            end
        end else if (conv_end && !restart && active) begin
            result[conv_idx] <= res_word;             // [R18] [R24]
        end
    end

    // Per result complete flags, set wins over clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conv_flag <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (conv_end && active && conv_idx == 3'(i)) begin
                    conv_flag[i] <= 1'b1;             // [R13]
                end else if (restart) begin
                    conv_flag[i] <= 1'b0;             // [R23]
                end
            end
        end
    end

    // Sequence complete flag, set wins over clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_flag <= 1'b0;
        end else if (seq_end && active) begin
            seq_flag <= 1'b1; // [R12]
        end else if (restart || scf_wclr) begin
            seq_flag <= 1'b0; // [R23]
        end
    end

    // Interrupt request from sequence flag
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_en & seq_flag;               // [R14]
        end
    end

    // Reference select for special conversions
    wire ref_sel_t spc_ref = (ch_base == SPC_LOW)  ? REF_LOW
                           : (ch_base == SPC_HIGH) ? REF_HIGH
                           : (ch_base == SPC_MID)  ? REF_MID
                           : REF_LOW;

    // Analog side controls from flops
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_analog <= '0;
        end else begin
            o_analog.powered       <= active;
            o_analog.channel       <= cur_ch;         // [R1] [R3]
            o_analog.ref_sel       <= ext_ch ? REF_NONE : spc_ref;  // [R5]

            o_analog.sample_cap    <= active && state == ST_CAP;    // [R22]
            o_analog.sample_amp    <= active && state == ST_AMP;
            o_analog.sample_direct <= active && state == ST_DIRECT;
            o_analog.converting    <= active && state == ST_CONV;

            o_analog.res10         <= res10;
            o_analog.dac_code      <= next_dac();
        end
    end

    // DAC code follows the approximation register
    function automatic logic [9:0] next_dac();
        return sar;
    endfunction

endmodule // adc_sequencer_control

// File: adc_seq_asserts.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
module adc_seq_asserts
    import adc_seq_pkg::*;
#(
    parameter int NUM_CH = 8
) (
    input wire logic        i_ref_clk, // Peripheral clock
    input wire logic        i_rst_n,   // Reset, active low
    input wire logic        psel,      // APB select
    input wire logic        penable,   // APB access phase
    input wire logic        pwrite,    // APB direction
    input wire logic [7:0]  paddr,     // APB address
    input wire logic [31:0] prdata,    // APB read data
    input wire logic        pready,    // APB ready
    input wire logic        pslverr,   // APB error
    input wire logic        i_stop,    // Processor STOP
    input wire analog_ctl_t o_analog   // Analog controls
);
    // Setup phase and address map decode
    wire logic setup  = psel && !penable;
    wire logic mapped = (paddr[1:0] == 2'b00) &&
                        (paddr <= OFS_STATUS || (paddr >= OFS_RESULT && paddr <= 8'h3C));
    wire logic active = o_analog.sample_cap || o_analog.sample_amp ||
                        o_analog.sample_direct || o_analog.converting;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    chk_ready_high: assert property (pready) else $error("ready low");
    chk_unmapped_err: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    chk_write_rdata: assert property (setup && pwrite |=> prdata == ZERO_WORD)
        else $error("read data not zero on write");
    chk_cap_then_amp: assert property ($fell(o_analog.sample_cap) && o_analog.powered
        |-> o_analog.sample_amp) else $error("amp phase missing");
    chk_amp_then_direct: assert property ($fell(o_analog.sample_amp) && o_analog.powered
        |-> o_analog.sample_direct || o_analog.sample_cap)
        else $error("direct phase missing");
    chk_direct_then_conv: assert property ($fell(o_analog.sample_direct) && o_analog.powered
        |-> o_analog.converting || o_analog.sample_cap)
        else $error("conversion missing");
    chk_one_phase: assert property ($onehot0({o_analog.sample_cap, o_analog.sample_amp,
        o_analog.sample_direct, o_analog.converting})) else $error("phases overlap");
    chk_down_quiet: assert property (!o_analog.powered |-> !active)
        else $error("activity while powered down");
    chk_stop_down: assert property (i_stop [*3] |-> !o_analog.powered && !active)
        else $error("stop did not power down");
endmodule // adc_seq_asserts

bind adc_sequencer_control adc_seq_asserts #(.NUM_CH(NUM_CH)) u_adc_seq_asserts (
    .i_ref_clk, .i_rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .i_stop, .o_analog
);

// File: adc_analog_model.sv
// Behavioural analog front end answering the approximation trials
`timescale 1ns/1ps
module adc_analog_model
    import adc_seq_pkg::*;
(
    input  wire logic        i_ref_clk, // Peripheral clock
    input  wire analog_ctl_t i_analog,  // Controls from the sequencer
    output logic             o_compare  // Comparator answer
);
    logic [9:0] level;    // Potential of the selected source
    logic [9:0] trial;    // Potential from the DAC arrays
    logic       idle_pat; // Changing level outside conversions

    // Source selection and DAC scaling
    always_comb begin
        case (i_analog.ref_sel)
            REF_LOW:  level = 10'h000;
            REF_HIGH: level = 10'h3FF;
            REF_MID:  level = 10'h200;
            default:  level = 10'h05A + 10'(i_analog.channel) * 10'h07B;
        endcase
        trial = i_analog.res10 ? i_analog.dac_code : {i_analog.dac_code[7:0], 2'b00};
    end

    // Toggle so an unused answer never looks stable
    always_ff @(posedge i_ref_clk) begin
        idle_pat <= (idle_pat === 1'b1) ? 1'b0 : 1'b1;
    end

    // Held sample against trial potential
    assign o_compare = i_analog.converting ? (level >= trial) : idle_pat;
endmodule // adc_analog_model

// File: adc_sequencer_control_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_sequencer_control_tb;
    import adc_seq_pkg::*;
    logic        i_ref_clk   = 1'b0; // Peripheral clock
    logic        i_rst_n     = 1'b0; // Reset, active low
    logic        psel        = 1'b0; // APB select
    logic        penable     = 1'b0; // APB access phase
    logic        pwrite      = 1'b0; // APB direction
    logic [7:0]  paddr       = 8'h00; // APB address
    logic [31:0] pwdata      = 32'h0000_0000; // APB write data
    logic        i_stop      = 1'b0; // Processor STOP
    logic        i_wait      = 1'b0; // Processor WAIT
    logic [31:0] prdata; // APB read data
    logic        pready; // APB ready
    logic        pslverr; // APB error
    logic        i_compare; // Comparator answer
    logic        o_irq; // Sequence request
    analog_ctl_t o_analog; // Analog controls
    int          miscompares = 0; // Mismatch count
    int          checked     = 0; // Comparison count
    int          seed        = 29; // Random seed
    int          cycles      = 0; // Timeout counter
    logic [31:0] q; // Last read word
    logic        err; // Last error flag
    logic [7:0]  ofs [6] = '{OFS_CTRL2, OFS_CTRL3, OFS_CTRL4, OFS_CTRL5, OFS_STATUS, OFS_RESULT};

    always #2.5 i_ref_clk = ~i_ref_clk;

    // Hang guard
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 100000) begin
            miscompares++;
            give_verdict();
        end
    end

    adc_sequencer_control #(.NUM_CH(8)) u_adc_sequencer_control (
        .i_ref_clk, .i_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .i_stop, .i_wait, .i_compare, .o_analog, .o_irq
    );
    adc_analog_model u_adc_analog_model (
        .i_ref_clk(i_ref_clk), .i_analog(o_analog), .o_compare(i_compare)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One APB transfer, request held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        @(posedge i_ref_clk);
        while (pready !== 1'b1) begin
            @(posedge i_ref_clk);
        end
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, err);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic [31:0] m = 32'hFFFF_FFFF);
        apb(1'b0, a, 32'h0000_0000, q, err);
        check(what, exp, q & m);
    endtask

    // Cycles until the request shows
    task automatic wait_irq(output int n);
        n = 0;
        @(negedge i_ref_clk);
        while (o_irq !== 1'b1) begin
            @(negedge i_ref_clk);
            n++;
        end
        @(posedge i_ref_clk);
    endtask

    // Expected result word
    function automatic logic [31:0] expect_res(int ch, logic spc, logic r10, logic lft);
        logic [9:0] v;
        v = spc ? (ch == 5 ? 10'h3FF : ch == 6 ? 10'h200 : 10'h000)
                : 10'h05A + 10'(ch) * 10'h07B;
        if (!r10) v = v >> 2;
        return 32'(v) << (lft ? (r10 ? 6 : 8) : 0);
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        int ch, n, d, t, len;
        logic r10, lft;
        logic [1:0] smp;
        logic [4:0] pre;
        logic [31:0] pu;
        pu = (32'h1 << C2_POWER_UP) | (32'h1 << C2_IRQ_EN);
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        for (int i = 0; i < 6; i++) begin
            rd_chk("reset word", ofs[i], ZERO_WORD);
        end
        apb(1'b0, 8'h14, ZERO_WORD, q, err);
        check("unmapped error", 32'h1, {31'h0, err});
        wr(OFS_RESULT, 32'h0000_FFFF);
        rd_chk("read-only result", OFS_RESULT, ZERO_WORD);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            ch  = $random(seed) & 7;
            r10 = 1'($random(seed));
            lft = 1'($random(seed));
            smp = 2'($random(seed));
            pre = (i == 0) ? 5'd31 : 5'($random(seed) & 3);
            wr(OFS_CTRL2, pu);
            wr(OFS_CTRL3, 32'h1 << C3_SINGLE);
            wr(OFS_CTRL4, {24'h00_0000, r10, smp, pre});
            wr(OFS_CTRL5, {24'h00_0000, lft, 4'h0, 3'(ch)});
            wait_irq(n);
            t = 6 + (2 << smp) + (r10 ? 12 : 10);
            d = 2 * (pre + 1);
            check("sequence time", 32'h1, 32'(n >= t * d - d && n <= t * d + d));
            rd_chk("result", OFS_RESULT, expect_res(ch, 1'b0, r10, lft));
            rd_chk("status", OFS_STATUS, 32'h0000_8001, 32'h0008_80FF);
            wr(OFS_CTRL4, {24'h00_0000, r10, smp, pre});
            rd_chk("flags cleared", OFS_STATUS, ZERO_WORD, 32'h0000_80FF);
            check("irq cancelled", ZERO_WORD, {31'h0, o_irq});
        end
        $display("test single done");
        wr(OFS_CTRL3, ZERO_WORD);
        wr(OFS_CTRL4, 32'h0000_0081);
        for (int m = 0; m < 4; m++) begin
            ch  = $random(seed) & 7;
            len = m[1] ? 8 : 4;
            wr(OFS_CTRL5, {24'h00_0000, 1'b0, m[1], 1'b0, m[0], 4'(ch)});
            wait_irq(n);
            for (int k = 0; k < len; k++) begin
                rd_chk("scan result", OFS_RESULT + 8'(4 * k),
                       expect_res(m[0] ? (ch + k) % 8 : ch, 1'b0, 1'b1, 1'b0));
            end
            rd_chk("scan flags", OFS_STATUS, m[1] ? 32'h0000_80FF : 32'h0000_800F,
                   32'h0000_80FF);
        end
        $display("test scan done");
        wr(OFS_CTRL3, 32'h1 << C3_SINGLE);
        for (int c = 4; c < 8; c++) begin
            wr(OFS_CTRL5, 32'(8 + c));
            wait_irq(n);
            rd_chk("reference result", OFS_RESULT, expect_res(c, 1'b1, 1'b1, 1'b0));
        end
        $display("test reference done");
        for (int s = 0; s < 5; s++) begin
            wr(OFS_CTRL2, pu | (s == 1 ? 32'h1 << C2_WAIT_PD : ZERO_WORD));
            wr(OFS_CTRL5, 32'h1 << C5_CONT);
            wait_irq(n);
            wr(OFS_STATUS, 32'h1 << ST_SEQ_FLAG);
            wait_irq(n);
            case (s)
                0, 1: i_wait <= 1'b1;
                2: i_stop <= 1'b1;
                3: wr(OFS_CTRL2, ZERO_WORD);
                default: wr(OFS_CTRL5, ZERO_WORD);
            endcase
            repeat (200) @(posedge i_ref_clk);
            rd_chk("busy after stop", OFS_STATUS, s == 0 ? 32'h0008_0000 : ZERO_WORD,
                   32'h0008_0000);
            i_wait <= 1'b0;
            i_stop <= 1'b0;
            @(posedge i_ref_clk);
        end
        $display("test continuous done");
        give_verdict();
    end
endmodule // adc_sequencer_control_tb
